// [design/ssm_serial_mode.sv]
// serial interface mode control, shift clock selection and 3-wire shifter
// What this block does
// - reset clears mode register to zero
// - mode register writable per bit or byte
// - bit 7 enables 3-wire operation
// - bit 2 picks msb or lsb first
// - bit 1 picks pin or baud clock
// - external async clock divided by sixteen
// - internal shift clock is clock over 2^(n+1)
// - baud value 80 hex selects async pin
`timescale 1ns/1ps
module ssm_serial_mode (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address
	input wire logic awvalid,
	output logic awready,
	input wire logic [ssm_pkg::SSM_ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	// axi4-lite write data
	input wire logic wvalid,
	output logic wready,
	input wire logic [ssm_pkg::SSM_DATA_W-1:0] wdata,
	input wire logic [3:0] wstrb,
	// axi4-lite write response
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// axi4-lite read address
	input wire logic arvalid,
	output logic arready,
	input wire logic [ssm_pkg::SSM_ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	// axi4-lite read data
	output logic rvalid,
	input wire logic rready,
	output logic [ssm_pkg::SSM_DATA_W-1:0] rdata,
	output logic [1:0] rresp,
	// serial pins
	input wire logic serial_clock_pin_i,
	input wire logic serial_data_in,
	output ssm_pkg::ssm_pin_out_s pins,
	// async clock pin and uart baud tick
	input wire logic async_clock_input_pin,
	output logic uart_baud_tick
);
	import ssm_pkg::*;

	// software-visible registers
	logic [7:0] serial_sync_mode_control_r; // mode register
	logic [7:0] baud_generator_control_r; // baud generator value
	logic [7:0] async_mode_control_r; // uart enable
	logic [7:0] rx_data_r; // last received byte
	logic [7:0] tx_r; // transmit shift register
	logic [3:0] bits_left_r; // bits still to sample
	ssm_state_e state_r; // shifter state
	// bus slave state
	logic aw_hold_r, w_hold_r; // captured address / data
	logic [15:0] aw_idx_r; // captured write index
	logic [31:0] w_data_r; // captured write data
	logic [3:0] w_strb_r; // captured strobes
	// pin synchronisers
	logic [1:0] sck_sync_r, sdi_sync_r, asy_sync_r; // two-flop chains
	logic sck_last_r, asy_last_r; // edge history after sync
	// clock generation
	logic [7:0] div_cnt_r; // prescaler count
	logic [3:0] asy_cnt_r; // external async edge count
	ssm_pin_out_s pins_nxt; // next pin values

	// decoded controls
	logic sync_serial_enable, first_bit_order, sync_clock_source;
	logic uart_en, async_ext, wr_fire, start_req, half_tick, fall_ev, rise_ev;
	logic [7:0] div_last;
	logic [3:0] baud_n;
	assign sync_serial_enable = serial_sync_mode_control_r[SSM_MODE_EN_BIT];
	assign first_bit_order = serial_sync_mode_control_r[SSM_MODE_ORDER_BIT];
	assign sync_clock_source = serial_sync_mode_control_r[SSM_MODE_CLK_BIT];
	assign uart_en = async_mode_control_r[SSM_ASYNC_EN_BIT];
	assign async_ext = uart_en && (baud_generator_control_r == SSM_BAUD_EXT);
	// n = upper field plus one, one to eight
	assign baud_n = {1'b0, baud_generator_control_r[6:4]} + 4'h1;
	// half period of 2^n cycles gives clock over 2^(n+1)
	assign div_last = 8'(({1'b0, 8'h00} | (9'h1 << baud_n)) - 9'h1);
	assign half_tick = (div_cnt_r == div_last);
	assign wr_fire = aw_hold_r && w_hold_r && !bvalid;

	// write address and data channels, taken in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_r <= 1'b0;
			w_hold_r <= 1'b0;
			aw_idx_r <= 16'h0000;
			w_data_r <= 32'h0000_0000;
			w_strb_r <= 4'h0;
		end else begin
			// address beat
			if (awvalid && awready) begin
				aw_hold_r <= 1'b1;
				aw_idx_r <= awaddr[SSM_ADDR_W-1:2];
			end else if (wr_fire) begin
				aw_hold_r <= 1'b0;
			end
			// data beat
			if (wvalid && wready) begin
				w_hold_r <= 1'b1;
				w_data_r <= wdata;
				w_strb_r <= wstrb;
			end else if (wr_fire) begin
				w_hold_r <= 1'b0;
			end
		end
	end
	assign awready = !aw_hold_r;
	assign wready = !w_hold_r;

	// write response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp <= SSM_RESP_OKAY;
		end else if (wr_fire) begin
			bvalid <= 1'b1;
			case (aw_idx_r)
				SSM_IDX_MODE, SSM_IDX_BAUD, SSM_IDX_ASYNC,
				SSM_IDX_DATA, SSM_IDX_BITOP, SSM_IDX_STATUS: bresp <= SSM_RESP_OKAY;
				default: bresp <= SSM_RESP_SLVERR;
			endcase
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	// mode register: byte write or single-bit operation
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			serial_sync_mode_control_r <= SSM_MODE_RST;
		end else if (wr_fire && w_strb_r[0]) begin
			if (aw_idx_r == SSM_IDX_MODE) begin
				// reserved bits stay zero
				serial_sync_mode_control_r <= w_data_r[7:0] & SSM_MODE_WMASK;
			end else if (aw_idx_r == SSM_IDX_BITOP) begin
				// one bit set or cleared, others kept
				serial_sync_mode_control_r[w_data_r[2:0]] <=
					w_data_r[SSM_BITOP_VAL_BIT] & SSM_MODE_WMASK[w_data_r[2:0]];
			end
		end
	end

	// baud and async mode registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			baud_generator_control_r <= SSM_BAUD_RST;
			async_mode_control_r <= SSM_ASYNC_RST;
		end else if (wr_fire && w_strb_r[0]) begin
			if (aw_idx_r == SSM_IDX_BAUD) baud_generator_control_r <= w_data_r[7:0];
			if (aw_idx_r == SSM_IDX_ASYNC) async_mode_control_r <= w_data_r[7:0];
		end
	end

	// read channel, one cycle after address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= SSM_RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rresp <= SSM_RESP_OKAY;
			unique case (araddr[SSM_ADDR_W-1:2])
				SSM_IDX_MODE: rdata <= {24'h000000, serial_sync_mode_control_r};
				SSM_IDX_BAUD: rdata <= {24'h000000, baud_generator_control_r};
				SSM_IDX_ASYNC: rdata <= {24'h000000, async_mode_control_r};
				SSM_IDX_DATA: rdata <= {24'h000000, rx_data_r};
				SSM_IDX_BITOP: rdata <= 32'h0000_0000;
				SSM_IDX_STATUS: rdata <= {24'h000000, bits_left_r, 1'b0, async_ext,
					uart_en, (state_r == SSM_SHIFT)};
				default: begin
					rdata <= 32'h0000_0000;
					rresp <= SSM_RESP_SLVERR;
				end
			endcase
		end else if (rready) begin
			rvalid <= 1'b0;
		end
	end
	assign arready = !rvalid;

	// pin synchronisers; first stage feeds only the second
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sck_sync_r <= 2'h3;
			sdi_sync_r <= 2'h0;
			asy_sync_r <= 2'h0;
			sck_last_r <= 1'b1;
			asy_last_r <= 1'b0;
		end else begin
			sck_sync_r <= {sck_sync_r[0], serial_clock_pin_i};
			sdi_sync_r <= {sdi_sync_r[0], serial_data_in};
			asy_sync_r <= {asy_sync_r[0], async_clock_input_pin};
			sck_last_r <= sck_sync_r[1];
			asy_last_r <= asy_sync_r[1];
		end
	end

	// prescaler; restarts with each transfer so the first half period is full
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_cnt_r <= 8'h00;
		end else if (start_req || half_tick) begin
			div_cnt_r <= 8'h00;
		end else begin
			div_cnt_r <= div_cnt_r + 8'h01;
		end
	end

	// uart baud tick: external pin over sixteen, else the prescaler
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			asy_cnt_r <= 4'h0;
			uart_baud_tick <= 1'b0;
		end else if (async_ext) begin
			if (asy_sync_r[1] && !asy_last_r) asy_cnt_r <= asy_cnt_r + 4'h1;
			uart_baud_tick <= asy_sync_r[1] && !asy_last_r &&
				(asy_cnt_r == SSM_ASYNC_DIV_LAST);
		end else begin
			asy_cnt_r <= 4'h0;
			uart_baud_tick <= uart_en && half_tick;
		end
	end

	// shift clock edges from the chosen source
	assign start_req = wr_fire && w_strb_r[0] && (aw_idx_r == SSM_IDX_DATA) &&
		sync_serial_enable && (state_r == SSM_IDLE);
	assign fall_ev = sync_clock_source ? (half_tick && pins.sck_o) :
		(!sck_sync_r[1] && sck_last_r);
	assign rise_ev = sync_clock_source ? (half_tick && !pins.sck_o) :
		(sck_sync_r[1] && !sck_last_r);

	// shifter state and counters
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r <= SSM_IDLE;
			bits_left_r <= 4'h0;
			tx_r <= 8'h00;
			rx_data_r <= 8'h00;
		end else if (!sync_serial_enable) begin
			// disabled: abandon any transfer and stay idle
			state_r <= SSM_IDLE;
			bits_left_r <= 4'h0;
		end else begin
			unique case (state_r)
				SSM_IDLE: if (start_req) begin
					state_r <= SSM_SHIFT;
					bits_left_r <= SSM_XFER_BITS;
					tx_r <= w_data_r[7:0];
				end
				SSM_SHIFT: begin
					// falling edge after the first of the transfer moves next bit up
					if (fall_ev && bits_left_r != SSM_XFER_BITS) begin
						tx_r <= first_bit_order ? {1'b0, tx_r[7:1]} : {tx_r[6:0], 1'b0};
					end
					// rising edge samples input
					if (rise_ev) begin
						rx_data_r <= first_bit_order ? {sdi_sync_r[1], rx_data_r[7:1]} :
							{rx_data_r[6:0], sdi_sync_r[1]};
						bits_left_r <= bits_left_r - 4'h1;
						if (bits_left_r == 4'h1) state_r <= SSM_IDLE;
					end
				end
			endcase
		end
	end

	// pin drive: clock driven only when enabled with internal source
	always_comb begin
		pins_nxt = pins;
		pins_nxt.sck_oe = sync_serial_enable && sync_clock_source;
		pins_nxt.sdo = first_bit_order ? tx_r[0] : tx_r[7];
		if (!sync_serial_enable || state_r == SSM_IDLE) begin
			pins_nxt.sck_o = 1'b1;
		end else if (sync_clock_source && half_tick) begin
			pins_nxt.sck_o = !pins.sck_o;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pins <= '{sck_o: 1'b1, sck_oe: 1'b0, sdo: 1'b0};
		end else begin
			pins <= pins_nxt;
		end
	end

	// checks
	property p_reset_mode;
		@(posedge aclk) !aresetn |=> serial_sync_mode_control_r == SSM_MODE_RST;
	endproperty
	a_reset_mode: assert property (p_reset_mode) else $error("mode not cleared by reset");

	property p_byte_write;
		@(posedge aclk) disable iff (!aresetn)
		wr_fire && w_strb_r[0] && aw_idx_r == SSM_IDX_MODE
		|=> serial_sync_mode_control_r == ($past(w_data_r[7:0]) & SSM_MODE_WMASK);
	endproperty
	a_byte_write: assert property (p_byte_write) else $error("byte write lost");

	property p_disabled_idle;
		@(posedge aclk) disable iff (!aresetn)
		!sync_serial_enable |=> state_r == SSM_IDLE ##1 pins.sck_o;
	endproperty
	a_disabled_idle: assert property (p_disabled_idle) else $error("shifter ran disabled");

	property p_enable_gate;
		@(posedge aclk) disable iff (!aresetn)
		$rose(state_r == SSM_SHIFT) |-> $past(sync_serial_enable);
	endproperty
	a_enable_gate: assert property (p_enable_gate) else $error("transfer without enable");

	property p_first_bit;
		@(posedge aclk) disable iff (!aresetn)
		start_req ##1 sync_serial_enable
		|=> pins.sdo == (first_bit_order ? tx_r[0] : tx_r[7]);
	endproperty
	a_first_bit: assert property (p_first_bit) else $error("wrong first bit");

	property p_clk_oe;
		@(posedge aclk) disable iff (!aresetn)
		##1 $stable(serial_sync_mode_control_r)
		|-> pins.sck_oe == $past(sync_serial_enable && sync_clock_source);
	endproperty
	a_clk_oe: assert property (p_clk_oe) else $error("clock drive wrong");

	property p_div16;
		@(posedge aclk) disable iff (!aresetn)
		uart_baud_tick && $past(async_ext) |-> $past(asy_cnt_r) == SSM_ASYNC_DIV_LAST;
	endproperty
	a_div16: assert property (p_div16) else $error("async divide not sixteen");

	property p_ext_select;
		@(posedge aclk) disable iff (!aresetn)
		uart_en && baud_generator_control_r == SSM_BAUD_EXT && !half_tick
		|=> !uart_baud_tick || $past(asy_sync_r[1] && !asy_last_r);
	endproperty
	a_ext_select: assert property (p_ext_select) else $error("baud tick not from pin");

	property p_half_period;
		@(posedge aclk) disable iff (!aresetn)
		half_tick && !start_req ##1 $stable(baud_generator_control_r)
		|-> div_cnt_r == 8'h00;
	endproperty
	a_half_period: assert property (p_half_period) else $error("prescaler not restarted");
endmodule // ssm_serial_mode

// [common/ssm_pkg.sv]
// shared constants and carrier types for the serial mode and clock select block
package ssm_pkg;
	// bus geometry
	localparam int SSM_ADDR_W = 18;
	localparam int SSM_DATA_W = 32;
	// register indices; byte address is four times the index
	localparam logic [15:0] SSM_IDX_MODE = 16'hFF72;
	localparam logic [15:0] SSM_IDX_BAUD = 16'hFF73;
	localparam logic [15:0] SSM_IDX_ASYNC = 16'hFF74;
	localparam logic [15:0] SSM_IDX_DATA = 16'hFF75;
	localparam logic [15:0] SSM_IDX_BITOP = 16'hFF76;
	localparam logic [15:0] SSM_IDX_STATUS = 16'hFF77;
	// reset values
	localparam logic [7:0] SSM_MODE_RST = 8'h00;
	localparam logic [7:0] SSM_BAUD_RST = 8'h00;
	localparam logic [7:0] SSM_ASYNC_RST = 8'h00;
	// mode register fields
	localparam int SSM_MODE_EN_BIT = 7;
	localparam int SSM_MODE_ORDER_BIT = 2;
	localparam int SSM_MODE_CLK_BIT = 1;
	localparam logic [7:0] SSM_MODE_WMASK = 8'h86;
	// async mode register field
	localparam int SSM_ASYNC_EN_BIT = 7;
	// baud value that selects the external async clock pin
	localparam logic [7:0] SSM_BAUD_EXT = 8'h80;
	// external async clock divide ratio, minus one
	localparam logic [3:0] SSM_ASYNC_DIV_LAST = 4'hF;
	// bit operation register fields
	localparam int SSM_BITOP_VAL_BIT = 3;
	// bits per transfer
	localparam logic [3:0] SSM_XFER_BITS = 4'h8;
	// axi responses
	localparam logic [1:0] SSM_RESP_OKAY = 2'h0;
	localparam logic [1:0] SSM_RESP_SLVERR = 2'h2;
	// pin outputs that travel together
	typedef struct packed {
		logic sck_o;
		logic sck_oe;
		logic sdo;
	} ssm_pin_out_s;
	// shift engine states
	typedef enum logic [0:0] {SSM_IDLE, SSM_SHIFT} ssm_state_e;
endpackage

// [dv/ssm_partner.sv]
// far-side serial peripheral model: clock source, data source and capture
`timescale 1ns/1ps
module ssm_partner (
	// clock and bench controls
	input wire logic aclk,
	input wire logic clr,
	input wire logic ext_run,
	input wire logic async_run,
	// pins from the device
	input wire logic sck_o,
	input wire logic sck_oe,
	input wire logic sdo,
	// pins to the device
	output logic sck_pin = 1'b1,
	output logic sdi = 1'b0,
	output logic async_pin = 1'b0,
	// captured byte and edge count
	output logic [7:0] cap = 8'h00,
	output logic [3:0] cnt = 4'h0
);
	logic prev_r = 1'b1; // last level of the shared clock line
	logic [2:0] div_r = 3'h0; // external shift clock half period
	logic [1:0] adiv_r = 2'h0; // async clock half period
	wire logic sck_e = sck_oe ? sck_o : sck_pin; // wire level seen by both sides
	// capture on rising, change data on falling
	always @(posedge aclk) begin
		prev_r <= sck_e;
		if (clr) begin
			cap <= 8'h00;
			cnt <= 4'h0;
		end else if (sck_e && !prev_r) begin
			cap <= {cap[6:0], sdo};
			cnt <= cnt + 4'h1;
		end
		if (!sck_e && prev_r) sdi <= ~sdi;
	end
	// clock pin is driven from here only, stands high outside frames
	always @(posedge aclk) begin
		div_r <= ext_run ? div_r + 3'h1 : 3'h0;
		if (ext_run && cnt < 4'h8 && div_r == 3'h7) sck_pin <= ~sck_pin;
		else if (!ext_run) sck_pin <= 1'b1;
	end
	// async clock runs only on request
	always @(posedge aclk) begin
		adiv_r <= async_run ? adiv_r + 2'h1 : 2'h0;
		if (async_run && adiv_r == 2'h3) async_pin <= ~async_pin;
	end
endmodule // ssm_partner

// [dv/ssm_serial_mode_tb_top.sv]
// self-checking bench for the serial mode and clock select block
`timescale 1ns/1ps
module ssm_serial_mode_tb_top;
	import ssm_pkg::*;
	logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [17:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata;
	logic [3:0] wstrb = 0, cnt;
	logic awready, wready, bvalid, arready, rvalid, uart_baud_tick, sck_pin, sdi, apin;
	logic [1:0] bresp, rresp, r;
	logic clr = 0, ext_run = 0, async_run = 0, ordr, ck;
	logic [7:0] cap, d, e, m;
	ssm_pin_out_s pins;
	int fail_count = 0, cmp_count = 0, seed = 95399, lo, oe, t, nb;
	// free-running clock, 4 ns
	always #2 aclk = ~aclk;
	ssm_serial_mode ssm_serial_mode_inst (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
		.awready(awready), .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready),
		.wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
		.arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid),
		.rready(rready), .rdata(rdata), .rresp(rresp), .serial_clock_pin_i(sck_pin),
		.serial_data_in(sdi), .pins(pins), .async_clock_input_pin(apin),
		.uart_baud_tick(uart_baud_tick));
	ssm_partner ssm_partner_inst (.aclk(aclk), .clr(clr), .ext_run(ext_run),
		.async_run(async_run), .sck_o(pins.sck_o), .sck_oe(pins.sck_oe), .sdo(pins.sdo),
		.sck_pin(sck_pin), .sdi(sdi), .async_pin(apin), .cap(cap), .cnt(cnt));
	// bit reversal for lsb-first expectations
	function automatic logic [7:0] rev(input logic [7:0] v);
		for (int k = 0; k < 8; k++) rev[k] = v[7-k];
	endfunction
	// compare and count
	task chk(input logic [31:0] s, input logic [31:0] x, input string msg);
		cmp_count++;
		if (s !== x) begin
			fail_count++;
			$display("[FAIL] %0t %s seen %h exp %h", $time, msg, s, x);
		end
	endtask
	// verdict and stop
	task end_sim;
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// axi4-lite write, address and data offered together
	task wr(input logic [15:0] idx, input logic [7:0] v, output logic [1:0] rs);
		logic aw, w;
		int n;
		@(posedge aclk);
		awaddr <= {idx, 2'b00};
		wdata <= {24'h0, v};
		wstrb <= 4'hF;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		aw = 1;
		w = 1;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
			if (bvalid === 1'b1 && !aw && !w) break;
			if (aw && awready === 1'b1) begin
				aw = 0;
				awvalid <= 0;
			end
			if (w && wready === 1'b1) begin
				w = 0;
				wvalid <= 0;
			end
		end while (n < 100);
		rs = bresp;
		bready <= 0;
		if (n >= 100) chk(0, 1, "write hang");
	endtask
	// axi4-lite read
	task rd(input logic [15:0] idx, output logic [7:0] v, output logic [1:0] rs);
		int n;
		@(posedge aclk);
		araddr <= {idx, 2'b00};
		arvalid <= 1;
		rready <= 1;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
			if (arvalid && arready === 1'b1) arvalid <= 0;
		end while (rvalid !== 1'b1 && n < 100);
		v = rdata[7:0];
		rs = rresp;
		rready <= 0;
		if (n >= 100) chk(0, 1, "read hang");
	endtask
	// hang guard
	initial begin
		#200000;
		fail_count++;
		end_sim;
	end
	// main sequence
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1;
		rd(SSM_IDX_MODE, d, r);
		chk(d, SSM_MODE_RST, "mode reset");
		chk(pins.sck_oe, 0, "idle pin");
		wr(SSM_IDX_MODE, 8'hFF, r);
		rd(SSM_IDX_MODE, d, r);
		chk(d, 8'h86, "byte write");
		rd(16'hFF78, d, r);
		chk(r, SSM_RESP_SLVERR, "unmapped");
		$display("test registers done");
		// transfers over order, clock source and divider
		for (int k = 0; k < 3; k++) begin
			ordr = k[0];
			ck = (k < 2);
			nb = 2 + ($random(seed) & 1);
			e = $random(seed);
			m = {1'b1, 4'h0, ordr, ck, 1'b0};
			wr(SSM_IDX_MODE, m, r);
			wr(SSM_IDX_BAUD, {1'b0, 3'(nb - 1), 4'h0}, r);
			clr <= 1;
			@(posedge aclk);
			clr <= 0;
			wr(SSM_IDX_DATA, e, r);
			ext_run <= !ck;
			lo = 0;
			oe = 0;
			t = 0;
			while (cnt !== 4'h8 && t < 5000) begin
				@(posedge aclk);
				t++;
				lo += (pins.sck_o === 1'b0);
				oe += (pins.sck_oe === 1'b1);
			end
			ext_run <= 0;
			repeat (8) @(posedge aclk);
			chk(cap, ordr ? rev(e) : e, "bit order");
			chk(ck ? lo : oe, ck ? (8 << nb) : 0, "shift clock");
			// partner data toggles on every falling edge, so received bits alternate
			rd(SSM_IDX_DATA, d, r);
			chk(d, ordr ? 8'h55 : 8'hAA, "received byte");
			wr(SSM_IDX_BITOP, 8'h07, r);
			rd(SSM_IDX_MODE, d, r);
			chk(d, m & 8'h7F, "bit write");
			$display("test transfer %0d done", k);
		end
		// disabled shifter ignores a start
		clr <= 1;
		@(posedge aclk);
		clr <= 0;
		wr(SSM_IDX_DATA, 8'hA5, r);
		oe = 0;
		repeat (64) @(posedge aclk) oe += (pins.sck_oe === 1'b1);
		chk(cnt, 0, "disabled edges");
		chk(oe, 0, "disabled drive");
		$display("test disabled done");
		// uart clock from async pin over sixteen
		wr(SSM_IDX_MODE, 8'h00, r);
		wr(SSM_IDX_BAUD, SSM_BAUD_EXT, r);
		wr(SSM_IDX_ASYNC, 8'h80, r);
		async_run <= 1;
		t = 0;
		repeat (256) @(posedge aclk) t += (uart_baud_tick === 1'b1);
		async_run <= 0;
		repeat (16) @(posedge aclk) t += (uart_baud_tick === 1'b1);
		chk(t, 2, "uart ticks");
		// status shows uart enabled and the pin selected as baud source
		rd(SSM_IDX_STATUS, d, r);
		chk(d, 8'h06, "uart status");
		$display("test uart done");
		end_sim;
	end
endmodule // ssm_serial_mode_tb_top
